/* File: design/joint_tlb_translation.sv */
/*
 * Joint translation buffer: 64 paired even/odd mappings, a parallel lookup
 * port for the pipeline, maintenance operations and the translation
 * registers reached by register number.
 * Duplicate matches are not reported: the lowest slot wins, which keeps the
 * answer deterministic but hides a software error.
 * Page masks are taken as contiguous from the low end; any other pattern
 * picks the page half by its highest set mask bit.
 * Assumes requests are synchronous to CLK_SYS and software keeps reserved
 * fields at zero; lookup answers one cycle after the request.
 */
`timescale 1ns/10ps
module joint_tlb_translation (
	input  wire logic        CLK_SYS,
	input  wire logic        SRST,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [4:0]  REG_NUM,
	input  wire logic [63:0] REG_WDATA,
	output logic      [63:0] REG_RDATA,
	input  wire logic        OP_VALID,
	input  wire logic [1:0]  OP_CODE,
	output logic             OP_DONE,
	input  wire logic        LK_VALID,
	input  wire logic [63:0] LK_VADDR,
	input  wire logic        LK_STORE,
	output logic             LK_DONE,
	output jtlb_pkg::lookup_s LK_RESULT
);

	jtlb_pkg::entry_s          entry_reg [jtlb_pkg::ENTRIES];
	logic [63:0]               key_reg;
	logic [63:0]               even_reg;
	logic [63:0]               odd_reg;
	logic [63:0]               mask_reg;
	logic                      probe_fail_reg;
	logic [5:0]                index_reg;
	logic [5:0]                random_reg;
	logic [5:0]                random_next;
	logic [5:0]                wired_reg;
	logic [63:0]               lk_match;
	logic [63:0]               pr_match;
	genvar                     g;
	logic                      lk_hit;
	logic [5:0]                lk_idx;
	logic                      pr_hit;
	logic [5:0]                pr_idx;
	logic                      op_go;
	jtlb_pkg::maint_op_e       op_code;
	jtlb_pkg::entry_s          new_entry;
	jtlb_pkg::entry_s          sel_entry;
	jtlb_pkg::frame_s          lk_frame;
	jtlb_pkg::lookup_s         lk_next;

	// Key match shared by lookup and probe
	function automatic logic entry_match(input jtlb_pkg::entry_s e, input logic [1:0] region,
		input logic [34:0] vpn, input logic [7:0] asid);
		logic [34:0] care;
		care = ~{23'h000000, e.page_size_mask};
		entry_match = (e.region == region)
			&& (((e.virt_page_pair ^ vpn) & care) == 35'h000000000)
			&& (e.is_global || (e.asid == asid));
	endfunction

	// Odd/even select bit sits just above the masked page offset
	function automatic logic odd_page(input logic [11:0] m, input logic [12:0] va);
		logic b;
		b = va[0];
		for (int i = 0; i < 12; i++) begin
			if (m[i]) begin
				b = va[i+1];
			end
		end
		odd_page = b;
	endfunction

	// Frame field extraction from a frame register image
	function automatic jtlb_pkg::frame_s to_frame(input logic [63:0] d);
		to_frame.phys_frame_number = d[jtlb_pkg::LO_PFN_MSB:jtlb_pkg::LO_PFN_LSB];
		to_frame.coher = d[jtlb_pkg::LO_COH_LSB+2:jtlb_pkg::LO_COH_LSB];
		to_frame.dirty = d[jtlb_pkg::LO_DIRTY_BIT];
		to_frame.valid = d[jtlb_pkg::LO_VALID_BIT];
	endfunction

	// Frame register image back from an entry, upper bits zero
	function automatic logic [63:0] from_frame(input jtlb_pkg::frame_s f, input logic g);
		from_frame = {22'h000000, f.phys_frame_number, f.coher, f.dirty, f.valid, g};
	endfunction

	// Priority pick shared by lookup and probe: lowest slot wins on duplicates
	function automatic logic [5:0] lowest_hit(input logic [63:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = jtlb_pkg::ENTRIES - 1; i >= 0; i--) begin
			if (v[i]) begin
				n = i[5:0];
			end
		end
		lowest_hit = n;
	endfunction

	// Key register image; filler and the zero field are rebuilt as zeros
	function automatic logic [63:0] key_image(input logic [1:0] region, input logic [34:0] vpn,
		input logic [7:0] asid);
		key_image = {region, 14'h0000, vpn, 5'h00, asid};
	endfunction

	// Frame image as written by software, reserved top bits forced low
	function automatic logic [63:0] frame_store(input logic [63:0] d);
		frame_store = {22'h000000, d[jtlb_pkg::LO_PFN_MSB:0]};
	endfunction

	// Page mask image; only the mask field survives
	function automatic logic [63:0] mask_image(input logic [11:0] m);
		mask_image = {39'h0000000000, m, 13'h0000};
	endfunction

	// One comparator pair per slot; the probe uses the key instead of an address
	generate
		for (g = 0; g < jtlb_pkg::ENTRIES; g = g + 1) begin : gen_slot
			assign lk_match[g] = entry_match(entry_reg[g], LK_VADDR[63:62],
				LK_VADDR[jtlb_pkg::KEY_VPN_MSB:jtlb_pkg::KEY_VPN_LSB], key_reg[7:0]);
			assign pr_match[g] = entry_match(entry_reg[g], key_reg[63:62],
				key_reg[jtlb_pkg::KEY_VPN_MSB:jtlb_pkg::KEY_VPN_LSB], key_reg[7:0]);
		end
	endgenerate

	// Hit flags and winning slot of the lookup and the probe
	assign lk_hit = |lk_match;
	assign lk_idx = lowest_hit(lk_match);
	assign pr_hit = |pr_match;
	assign pr_idx = lowest_hit(pr_match);

	// Lookup answer: valid flag is checked only after matching
	always_comb begin
		sel_entry = entry_reg[lk_idx];
		lk_frame = odd_page(sel_entry.page_size_mask, LK_VADDR[24:12]) ? sel_entry.odd
			: sel_entry.even;
		lk_next = '0;
		lk_next.miss = ~lk_hit;
		if (lk_hit) begin
			lk_next.phys_frame_number = lk_frame.phys_frame_number;
			lk_next.coher = lk_frame.coher;
			lk_next.dirty = lk_frame.dirty;
			lk_next.valid = lk_frame.valid;
			lk_next.cached = (lk_frame.coher == jtlb_pkg::COH_CACHED_NC);
			lk_next.invalid = ~lk_frame.valid;
			lk_next.modified = lk_frame.valid & LK_STORE & ~lk_frame.dirty;
		end
	end

	// Lookup completion strobe, one cycle after each request
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			LK_DONE <= 1'b0;
		end else begin
			LK_DONE <= LK_VALID;
		end
	end

	// Pipeline result is held until the next lookup
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			LK_RESULT <= '0;
		end else if (LK_VALID) begin
			LK_RESULT <= lk_next;
		end
	end

	// Entry image built from the staged registers
	assign op_code = jtlb_pkg::maint_op_e'(OP_CODE);
	assign op_go = OP_VALID;
	always_comb begin
		new_entry.region = key_reg[63:62];
		new_entry.virt_page_pair = key_reg[47:13];
		new_entry.asid = key_reg[7:0];
		new_entry.page_size_mask = mask_reg[jtlb_pkg::MASK_MSB:jtlb_pkg::MASK_LSB];
		new_entry.is_global = even_reg[jtlb_pkg::LO_GLOBAL_BIT]
			& odd_reg[jtlb_pkg::LO_GLOBAL_BIT];
		new_entry.even = to_frame(even_reg);
		new_entry.odd = to_frame(odd_reg);
	end

	// Entry store; cleared at reset so early lookups find only invalid frames
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			for (int i = 0; i < jtlb_pkg::ENTRIES; i++) begin
				entry_reg[i] <= '0;
			end
		end else if (op_go && (op_code == jtlb_pkg::OP_WRITE_IDX)) begin
			entry_reg[index_reg] <= new_entry;
		end else if (op_go && (op_code == jtlb_pkg::OP_WRITE_RAND)) begin
			entry_reg[random_reg] <= new_entry;
		end
	end

	// Operation completion strobe
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			OP_DONE <= 1'b0;
		end else begin
			OP_DONE <= op_go;
		end
	end

	// Index register: software write, probe hit number
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			index_reg <= 6'h00;
		end else if (op_go && (op_code == jtlb_pkg::OP_PROBE)) begin
			index_reg <= pr_hit ? pr_idx : index_reg;
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_INDEX)) begin
			index_reg <= REG_WDATA[5:0];
		end
	end

	// Probe failure flag: a probe in the same cycle wins over a software write
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			probe_fail_reg <= 1'b0;
		end else if (op_go && (op_code == jtlb_pkg::OP_PROBE)) begin
			probe_fail_reg <= ~pr_hit;
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_INDEX)) begin
			probe_fail_reg <= 1'b0;
		end
	end

	// Replacement counter walks down from the top to the wired floor
	always_comb begin
		if (random_reg <= wired_reg) begin
			random_next = jtlb_pkg::RANDOM_RESET;
		end else begin
			random_next = random_reg - 6'h01;
		end
	end

	// Counter restarts at the top whenever the wired floor moves
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			random_reg <= jtlb_pkg::RANDOM_RESET;
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_WIRED)) begin
			random_reg <= jtlb_pkg::RANDOM_RESET;
		end else begin
			random_reg <= random_next;
		end
	end

	// Wired floor: slots below it are never picked by a random write
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			wired_reg <= jtlb_pkg::WIRED_RESET;
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_WIRED)) begin
			wired_reg <= REG_WDATA[5:0];
		end
	end

	// Key register; a read-indexed op wins over a software write
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			key_reg <= '0;
		end else if (op_go && (op_code == jtlb_pkg::OP_READ_IDX)) begin
			key_reg <= key_image(entry_reg[index_reg].region,
				entry_reg[index_reg].virt_page_pair, entry_reg[index_reg].asid);
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_KEY)) begin
			key_reg <= key_image(REG_WDATA[63:62], REG_WDATA[47:13],
				REG_WDATA[7:0]);
		end
	end

	// Even frame register; refill shows the entry's global flag in bit 0
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			even_reg <= '0;
		end else if (op_go && (op_code == jtlb_pkg::OP_READ_IDX)) begin
			even_reg <= from_frame(entry_reg[index_reg].even, entry_reg[index_reg].is_global);
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_EVEN)) begin
			even_reg <= frame_store(REG_WDATA);
		end
	end

	// Odd frame register; same layout as the even one
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			odd_reg <= '0;
		end else if (op_go && (op_code == jtlb_pkg::OP_READ_IDX)) begin
			odd_reg <= from_frame(entry_reg[index_reg].odd, entry_reg[index_reg].is_global);
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_ODD)) begin
			odd_reg <= frame_store(REG_WDATA);
		end
	end

	// Page mask register; bits outside the mask field are never stored
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			mask_reg <= '0;
		end else if (op_go && (op_code == jtlb_pkg::OP_READ_IDX)) begin
			mask_reg <= mask_image(entry_reg[index_reg].page_size_mask);
		end else if (REG_WR && (REG_NUM == jtlb_pkg::REG_MASK)) begin
			mask_reg <= mask_image(REG_WDATA[jtlb_pkg::MASK_MSB:jtlb_pkg::MASK_LSB]);
		end
	end

	// Register read port; unmapped numbers read zero
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			if (REG_NUM == jtlb_pkg::REG_INDEX) begin
				REG_RDATA <= {32'h00000000, probe_fail_reg, 25'h0000000, index_reg};
			end else if (REG_NUM == jtlb_pkg::REG_RANDOM) begin
				REG_RDATA <= {58'h000000000000000, random_reg};
			end else if (REG_NUM == jtlb_pkg::REG_EVEN) begin
				REG_RDATA <= even_reg;
			end else if (REG_NUM == jtlb_pkg::REG_ODD) begin
				REG_RDATA <= odd_reg;
			end else if (REG_NUM == jtlb_pkg::REG_MASK) begin
				REG_RDATA <= mask_reg;
			end else if (REG_NUM == jtlb_pkg::REG_WIRED) begin
				REG_RDATA <= {58'h000000000000000, wired_reg};
			end else if (REG_NUM == jtlb_pkg::REG_KEY) begin
				REG_RDATA <= key_reg;
			end else begin
				REG_RDATA <= '0;
			end
		end
	end

endmodule

/* File: design/jtlb_pkg.sv */
/*
 * Shared constants and types of the joint translation buffer: register
 * numbers, field positions, reset values, entry layout and operation codes.
 * Assumes a 64-bit core that moves whole doublewords into these registers.
 */
package jtlb_pkg;

	localparam int ENTRIES  = 64;
	localparam int IDX_W    = 6;

	// Register numbers on the coprocessor move port
	localparam logic [4:0] REG_INDEX  = 5'h00;
	localparam logic [4:0] REG_RANDOM = 5'h01;
	localparam logic [4:0] REG_EVEN   = 5'h02;
	localparam logic [4:0] REG_ODD    = 5'h03;
	localparam logic [4:0] REG_MASK   = 5'h05;
	localparam logic [4:0] REG_WIRED  = 5'h06;
	localparam logic [4:0] REG_KEY    = 5'h0a;

	// Field positions
	localparam int KEY_REGION_LSB = 62;
	localparam int KEY_VPN_LSB    = 13;
	localparam int KEY_VPN_MSB    = 47;
	localparam int KEY_ASID_MSB   = 7;
	localparam int LO_PFN_LSB     = 6;
	localparam int LO_PFN_MSB     = 41;
	localparam int LO_COH_LSB     = 3;
	localparam int LO_DIRTY_BIT   = 2;
	localparam int LO_VALID_BIT   = 1;
	localparam int LO_GLOBAL_BIT  = 0;
	localparam int MASK_LSB       = 13;
	localparam int MASK_MSB       = 24;
	localparam int PROBE_FAIL_BIT = 31;
	localparam int PAGE_SEL_LSB   = 12;

	// Values after reset
	localparam logic [IDX_W-1:0] RANDOM_RESET = 6'h3f;
	localparam logic [IDX_W-1:0] WIRED_RESET  = 6'h00;

	// Coherency codes
	localparam logic [2:0] COH_UNCACHED   = 3'h2;
	localparam logic [2:0] COH_CACHED_NC  = 3'h3;
	localparam logic [2:0] COH_UNCACHED_A = 3'h7;

	// Region selector codes
	localparam logic [1:0] REGION_USER  = 2'h0;
	localparam logic [1:0] REGION_SUPER = 2'h1;
	localparam logic [1:0] REGION_KERN  = 2'h3;

	typedef enum logic [1:0] {
		OP_PROBE      = 2'h0,
		OP_READ_IDX   = 2'h1,
		OP_WRITE_IDX  = 2'h3,
		OP_WRITE_RAND = 2'h2
	} maint_op_e;

	typedef struct packed {
		logic [35:0] phys_frame_number;
		logic [2:0]  coher;
		logic        dirty;
		logic        valid;
	} frame_s;

	typedef struct packed {
		logic [1:0]  region;
		logic [34:0] virt_page_pair;
		logic [7:0]  asid;
		logic [11:0] page_size_mask;
		logic        is_global;
		frame_s      even;
		frame_s      odd;
	} entry_s;

	typedef struct packed {
		logic [35:0] phys_frame_number;
		logic [2:0]  coher;
		logic        dirty;
		logic        valid;
		logic        cached;
		logic        miss;
		logic        invalid;
		logic        modified;
	} lookup_s;

endpackage

/* File: verification/jtlb_properties.sv */
/* Checker of the lookup, operation and register read ports.
   Assumes it is bound into the translation buffer top module. */
`timescale 1ns/10ps
module jtlb_checker (
	input wire logic              CLK_SYS,
	input wire logic              SRST,
	input wire logic              REG_RD,
	input wire logic [4:0]        REG_NUM,
	input wire logic [63:0]       REG_RDATA,
	input wire logic              OP_VALID,
	input wire logic              OP_DONE,
	input wire logic              LK_VALID,
	input wire logic              LK_STORE,
	input wire logic              LK_DONE,
	input wire jtlb_pkg::lookup_s LK_RESULT
);
	// One clock domain; every check pauses while reset is applied
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (SRST);

	a_lookup_answer: assert property (LK_VALID |=> LK_DONE)
		else $error("lookup not answered");
	a_op_answer: assert property (OP_VALID |=> OP_DONE)
		else $error("operation not answered");
	a_miss_clean: assert property (LK_DONE && LK_RESULT.miss |-> LK_RESULT == 'h4)
		else $error("miss carries a translation");
	a_cache_coh: assert property (LK_DONE |-> LK_RESULT.cached == (LK_RESULT.coher == 3'h3))
		else $error("cached flag wrong");
	a_invalid_flag: assert property (LK_DONE && !LK_RESULT.miss |->
		LK_RESULT.invalid == !LK_RESULT.valid) else $error("invalid flag wrong");
	a_store_protect: assert property (LK_DONE && !LK_RESULT.miss |->
		LK_RESULT.modified == (LK_RESULT.valid && $past(LK_STORE) && !LK_RESULT.dirty))
		else $error("modification flag wrong");
	// Reset clears the result, so the edge just after reset is excused
	a_result_hold: assert property (!LK_DONE && !$past(SRST) |-> $stable(LK_RESULT))
		else $error("result moved without lookup");
	a_key_filler: assert property (REG_RD && REG_NUM == 5'h0a |=>
		REG_RDATA[61:48] == 14'h0 && REG_RDATA[12:8] == 5'h0) else $error("key zero bits set");
	a_frame_zero: assert property (REG_RD && REG_NUM[4:1] == 4'h1 |=>
		REG_RDATA[63:42] == 22'h0) else $error("frame upper bits set");
	a_unmapped_zero: assert property (REG_RD && REG_NUM == 5'h04 |=> REG_RDATA == 64'h0)
		else $error("unmapped read not zero");

	c_miss: cover property (LK_DONE && LK_RESULT.miss);
	c_modified: cover property (LK_DONE && LK_RESULT.modified);
	c_cached: cover property (LK_DONE && LK_RESULT.cached);
endmodule

bind joint_tlb_translation jtlb_checker u_chk (.CLK_SYS(CLK_SYS), .SRST(SRST),
	.REG_RD(REG_RD), .REG_NUM(REG_NUM), .REG_RDATA(REG_RDATA), .OP_VALID(OP_VALID),
	.OP_DONE(OP_DONE), .LK_VALID(LK_VALID), .LK_STORE(LK_STORE), .LK_DONE(LK_DONE),
	.LK_RESULT(LK_RESULT));

/* File: verification/pipe_model.sv */
/* Pipeline side model: issues one lookup at a time and collects the answer.
   Assumes the block answers within a few core clock cycles. */
`timescale 1ns/10ps
module pipe_model (
	input  wire logic              CLK_SYS,
	input  wire logic              LK_DONE,
	input  wire jtlb_pkg::lookup_s LK_RESULT,
	output logic                   LK_VALID,
	output logic [63:0]            LK_VADDR,
	output logic                   LK_STORE
);
	logic hung = 1'b0;

	// Idle request lines at time zero
	initial begin
		LK_VALID = 1'b0;
		LK_VADDR = 64'h0;
		LK_STORE = 1'b0;
	end

	// Released lines show the inverse so a stale address never matches by luck
	task automatic look(input logic [63:0] a, input logic st, output jtlb_pkg::lookup_s r);
		int n;
		@(posedge CLK_SYS);
		LK_VALID <= 1'b1;
		LK_VADDR <= a;
		LK_STORE <= st;
		@(posedge CLK_SYS);
		LK_VALID <= 1'b0;
		LK_VADDR <= ~a;
		LK_STORE <= ~st;
		#1;
		for (n = 0; n < 4 && LK_DONE !== 1'b1; n++) @(posedge CLK_SYS) #1;
		hung = (LK_DONE !== 1'b1);
		r = LK_RESULT;
	endtask
endmodule

/* File: verification/tb_joint_tlb_translation.sv */
/* Bench: register, operation and lookup traffic with expected answers.
   Assumes pipe_model drives lookups and the checker is bound in. */
`timescale 1ns/10ps
module tb_joint_tlb_translation;
	localparam logic [34:0] VPN = 35'h12345678;
	localparam logic [35:0] PE  = 36'habcdef012;
	localparam logic [35:0] PO  = 36'h0f0f0f0f0;
	localparam logic [63:0] VA  = {2'h3, 14'h0, VPN, 13'h0};
	localparam logic [63:0] GE  = {22'h0, PE, 6'h1b};
	localparam logic [63:0] GO  = {22'h0, PO, 6'h1f};
	localparam logic [2:0]  COHS [4] = '{3'h2, 3'h3, 3'h7, 3'h5};
	localparam jtlb_pkg::lookup_s MISS = 'h4;
	logic              CLK_SYS   = 1'b0;
	logic              SRST      = 1'b1;
	logic              REG_WR    = 1'b0;
	logic              REG_RD    = 1'b0;
	logic [4:0]        REG_NUM   = 5'h00;
	logic [63:0]       REG_WDATA = 64'h0;
	logic              OP_VALID  = 1'b0;
	logic [1:0]        OP_CODE   = 2'h0;
	logic [63:0]       REG_RDATA, LK_VADDR, d;
	logic              OP_DONE, LK_VALID, LK_STORE, LK_DONE;
	jtlb_pkg::lookup_s LK_RESULT, r;
	int                miscompares = 0;
	int                n_compared  = 0;
	int                i;

	always #25 CLK_SYS = ~CLK_SYS;

	joint_tlb_translation u_dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_NUM(REG_NUM), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_DONE(OP_DONE), .LK_VALID(LK_VALID),
		.LK_VADDR(LK_VADDR), .LK_STORE(LK_STORE), .LK_DONE(LK_DONE), .LK_RESULT(LK_RESULT));
	pipe_model u_pipe (.CLK_SYS(CLK_SYS), .LK_DONE(LK_DONE), .LK_RESULT(LK_RESULT),
		.LK_VALID(LK_VALID), .LK_VADDR(LK_VADDR), .LK_STORE(LK_STORE));

	// Verdict and the only place the run ends
	task automatic end_of_test;
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Register moves: strobe for one cycle, data lines inverted once released
	task automatic wr(input logic [4:0] n, input logic [63:0] v);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_NUM <= n;
		REG_WDATA <= v;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
		REG_WDATA <= ~v;
	endtask

	task automatic rc(input logic [4:0] n, input logic [63:0] e);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_NUM <= n;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 chk($sformatf("reg %0d", n), REG_RDATA, e);
	endtask

	task automatic key(input logic [34:0] v, input logic [7:0] a);
		wr(5'h0a, {2'h3, 14'h0, v, 5'h0, a});
	endtask

	task automatic op(input logic [1:0] c);
		@(posedge CLK_SYS);
		OP_VALID <= 1'b1;
		OP_CODE <= c;
		@(posedge CLK_SYS);
		OP_VALID <= 1'b0;
		#1 chk("op done", OP_DONE, 1'b1);
	endtask

	// Expected lookup answer for a matched page
	function automatic jtlb_pkg::lookup_s hit(logic [35:0] p, logic [2:0] c, logic dv, logic v,
		logic st);
		return {p, c, dv, v, c == 3'h3, 1'b0, !v, v & st & !dv};
	endfunction

	task automatic lc(input logic [63:0] va, input logic st, input jtlb_pkg::lookup_s e);
		u_pipe.look(va, st, r);
		if (u_pipe.hung) begin
			miscompares++;
			end_of_test();
		end
		chk("lookup", 64'(r), 64'(e));
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge CLK_SYS);
		SRST <= 1'b0;
		rc(5'h06, 64'h0);
		rc(5'h00, 64'h0);
		rc(5'h04, 64'h0);
		wr(5'h0a, {2'h3, 14'h3fff, VPN, 5'h0, 8'h5a});
		rc(5'h0a, {2'h3, 14'h0, VPN, 5'h0, 8'h5a});
		wr(5'h02, {22'h0, PE, 6'h1a});
		wr(5'h03, {22'h0, PO, 6'h16});
		rc(5'h03, {22'h0, PO, 6'h16});
		wr(5'h00, 64'h5);
		op(2'h3);
		lc(VA, 1'b0, hit(PE, 3'h3, 1'b0, 1'b1, 1'b0));
		lc(VA, 1'b1, hit(PE, 3'h3, 1'b0, 1'b1, 1'b1));
		lc(VA | 64'h1000, 1'b1, hit(PO, 3'h2, 1'b1, 1'b1, 1'b1));
		lc({2'h0, VA[61:0]}, 1'b0, MISS);
		for (i = 0; i < 4; i++) begin
			wr(5'h03, {22'h0, PO, COHS[i], 1'b1, i != 3, 1'b0});
			op(2'h3);
			lc(VA | 64'h1000, 1'b0, hit(PO, COHS[i], 1'b1, i != 3, 1'b0));
		end
		// Global only on the even half keeps the tag compare
		wr(5'h02, GE);
		op(2'h3);
		key(VPN, 8'h11);
		lc(VA, 1'b0, MISS);
		wr(5'h03, GO);
		key(VPN, 8'h5a);
		op(2'h3);
		key(VPN, 8'h11);
		lc(VA, 1'b0, hit(PE, 3'h3, 1'b0, 1'b1, 1'b0));
		// Read back the entry over cleared registers
		wr(5'h02, 64'h0);
		wr(5'h03, 64'h0);
		key(35'h0, 8'h00);
		op(2'h1);
		rc(5'h0a, {2'h3, 14'h0, VPN, 5'h0, 8'h5a});
		rc(5'h02, GE);
		rc(5'h03, GO);
		wr(5'h00, 64'h0);
		op(2'h0);
		rc(5'h00, 64'h5);
		key(35'h1, 8'h5a);
		op(2'h0);
		rc(5'h00, 64'h80000005);
		// Four-page mask: va bit 13 ignored, bit 14 picks the odd page
		wr(5'h00, 64'h5);
		wr(5'h05, 64'h6000);
		rc(5'h05, 64'h6000);
		key(VPN, 8'h5a);
		op(2'h3);
		lc(VA | 64'h2000, 1'b0, hit(PE, 3'h3, 1'b0, 1'b1, 1'b0));
		lc(VA | 64'h4000, 1'b0, hit(PO, 3'h3, 1'b1, 1'b1, 1'b0));
		lc(VA | 64'h8000, 1'b0, MISS);
		// Random write must land above the wired entries
		wr(5'h06, 64'h3c);
		rc(5'h01, 64'h3e);
		rc(5'h06, 64'h3c);
		key(35'h2, 8'h5a);
		op(2'h2);
		op(2'h0);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_NUM <= 5'h00;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1 d = REG_RDATA;
		chk("random slot", d >= 64'h3c && d <= 64'h3f, 64'h1);
		end_of_test();
	end
endmodule
